// *** common/slhp_pkg.sv ***
// shared constants and types for the serial link host port
package slhp_pkg;
    // clock and link bit timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int BIT_NS_SLOW = 100;
    localparam int BIT_NS_FAST = 50;
    localparam logic [3:0] BIT_CYC_SLOW = 4'((BIT_NS_SLOW + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] BIT_CYC_FAST = 4'((BIT_NS_FAST + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // register select codes
    localparam logic [1:0] SEL_RX_DATA = 2'h0;
    localparam logic [1:0] SEL_TX_DATA = 2'h1;
    localparam logic [1:0] SEL_RX_STAT = 2'h2;
    localparam logic [1:0] SEL_TX_STAT = 2'h3;

    // status register fields
    localparam int FLAG_BIT = 0;
    localparam int IE_BIT = 1;

    // link framing
    localparam logic [3:0] DATA_FRAME_BITS = 4'hB;
    localparam logic [3:0] ACK_FRAME_BITS = 4'h2;

    // receive buffer shape
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 32;

    // values after reset, and the fixed value of undefined reads
    localparam logic OUT_READY_RESET = 1'b1;
    localparam logic IE_RESET = 1'b0;
    localparam logic [7:0] UNDEFINED_READ = 8'h00;

    typedef struct packed {
        logic select_n;
        logic [1:0] reg_sel;
        logic rd;
        logic [7:0] data;
        logic serial;
        logic rate;
    } slhp_pins_type;

    typedef struct packed {
        logic [1:0] reg_sel;
        logic rd;
    } slhp_access_type;

    localparam slhp_pins_type PINS_RESET = '{select_n: 1'b1, reg_sel: 2'h0, rd: 1'b0,
                                             data: 8'h00, serial: 1'b0, rate: 1'b0};
    localparam int PIN_BITS = $bits(slhp_pins_type);

    typedef enum logic [1:0] {TX_IDLE = 2'h0, TX_SEND = 2'h1} slhp_tx_state_type;
    typedef enum logic [1:0] {
        RX_IDLE = 2'h0, RX_TYPE = 2'h1, RX_DATA = 2'h3, RX_STOP = 2'h2
    } slhp_rx_state_type;
endpackage

// *** design/slhp_fifo.sv ***
// receive byte buffer with valid/ready on both sides
`timescale 1ns/10ps
module slhp_fifo import slhp_pkg::*; #(
    parameter int WIDTH = FIFO_WIDTH,
    parameter int DEPTH = FIFO_DEPTH
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // filling side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // draining side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_reg;
    logic [AW:0] rd_ptr_reg;
    logic full;
    logic empty;
    logic push;
    logic pop;

    assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                  (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
    assign empty = wr_ptr_reg == rd_ptr_reg;
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_ptr_reg[AW-1:0]];
    assign push = in_valid && !full;
    assign pop = out_ready && !empty;

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
        end else if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rd_ptr_reg <= '0;
        end else if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end
    end

    fifo_push_a: assert property (@(posedge clock) disable iff (!rst_n)
        push && !pop |=> out_valid && !$stable(wr_ptr_reg)) else $error("push lost");
endmodule

// *** design/slhp_top.sv ***
// parallel host port of the serial link adaptor
`timescale 1ns/10ps
// Summary of operation
// - data bus driven only while selected for a read, else released
// - host sets select and direction first; write data taken at select rise
// - register select and direction latched at select fall
// - decode: 00 read data, 01 write data, 10 input status, 11 output status
// - receive register holds last data byte, never an acknowledge; writes ignored; here it gives the oldest unread of up to 32 buffered bytes
// - data-present set on byte arrival, cleared only by data read or reset
// - each status register has a writable, readable interrupt enable
// - receive interrupt is enable AND data-present
// - receive interrupt rises within 14 bit times of packet start
// - data read sends an acknowledge 0.8 to 2.5 bits after select rise; with rate select high it starts 7 to 8 clocks, about 2.3 to 2.7 bits, after
// - transmit write clears output-ready and sends a data packet
// - output-ready sets after byte sent and acknowledge received
// - output-ready cleared only by transmit write, set by reset
// - reading transmit register gives undefined data, no side effect
// - transmit interrupt is enable AND output-ready
// - bit time is 100 ns at 10 Mbit/s
// - data packet 1,1,eight bits lsb first,0; acknowledge 1,0; idle low
// - reset holds link and interrupts low, enables cleared, bus released
// - rate select low runs 10 Mbit/s; high should run 20 Mbit/s but runs 60 ns bits (3 clocks), about 16.7 Mbit/s
module slhp_top import slhp_pkg::*; (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // host bus
    input wire logic HOST_SELECT_LOW,
    input wire logic [1:0] REGISTER_SELECT_LINES,
    input wire logic READ_WRITE_LINE,
    input wire logic [7:0] HOST_BYTE_BUS_IN,
    output logic [7:0] HOST_BYTE_BUS_OUT,
    output logic HOST_BYTE_BUS_OE,
    // interrupts
    output logic RECEIVE_IRQ,
    output logic TRANSMIT_IRQ,
    // serial link
    input wire logic SERIAL_IN,
    output logic SERIAL_OUT,
    input wire logic SERIAL_RATE_SELECT
);
    function automatic logic is_access(slhp_access_type a, logic [1:0] sel, logic rd);
        return (a.reg_sel == sel) && (a.rd == rd);
    endfunction

    slhp_pins_type pins_raw;
    slhp_pins_type pins_s1_reg;
    slhp_pins_type pins_s2_reg;
    slhp_pins_type pins_s3_reg;
    slhp_pins_type pins_reg;
    logic cs_prev_reg;
    logic cs_fall;
    logic cs_rise;
    slhp_access_type access_reg;
    slhp_access_type access_now;
    logic selected_reg;
    logic rx_read;
    logic tx_write;
    logic rx_stat_write;
    logic tx_stat_write;
    logic [7:0] read_value;
    logic [3:0] bit_cyc;
    logic rx_ie_reg;
    logic tx_ie_reg;
    logic out_ready_reg;
    logic data_done_reg;
    logic ack_seen_reg;
    logic ack_pending_reg;
    logic tx_pending_reg;
    logic [7:0] tx_byte_reg;
    slhp_tx_state_type tx_state_reg;
    logic [3:0] tx_div_reg;
    logic [3:0] tx_cnt_reg;
    logic [9:0] tx_shift_reg;
    logic tx_sending_data_reg;
    logic tx_tick;
    logic start_ack;
    logic start_data;
    logic data_end;
    slhp_rx_state_type rx_state_reg;
    logic [3:0] rx_cnt_reg;
    logic [2:0] rx_idx_reg;
    logic [7:0] rx_shift_reg;
    logic rx_push_reg;
    logic ack_pulse_reg;
    logic serial_prev_reg;
    logic fifo_in_ready;
    logic data_present;
    logic [7:0] receive_byte;

    // pin sampling: three stages, a change counts when stages two and three agree
    assign pins_raw = '{select_n: HOST_SELECT_LOW, reg_sel: REGISTER_SELECT_LINES,
                        rd: READ_WRITE_LINE, data: HOST_BYTE_BUS_IN,
                        serial: SERIAL_IN, rate: SERIAL_RATE_SELECT};

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            pins_s1_reg <= PINS_RESET;
            pins_s2_reg <= PINS_RESET;
            pins_s3_reg <= PINS_RESET;
        end else begin
            pins_s1_reg <= pins_raw;
            pins_s2_reg <= pins_s1_reg;
            pins_s3_reg <= pins_s2_reg;
        end
    end

    for (genvar i = 0; i < PIN_BITS; i++) begin : g_agree
        always_ff @(posedge CLOCK) begin
            if (!RST_N) begin
                pins_reg[i] <= PINS_RESET[i];
            end else if (pins_s2_reg[i] == pins_s3_reg[i]) begin
                pins_reg[i] <= pins_s3_reg[i];
            end
        end
    end

    // all pins share one delay, so select, address and data stay aligned
    assign cs_fall = cs_prev_reg && !pins_reg.select_n;
    assign cs_rise = !cs_prev_reg && pins_reg.select_n;
    assign access_now = '{reg_sel: pins_reg.reg_sel, rd: pins_reg.rd};
    assign bit_cyc = pins_reg.rate ? BIT_CYC_FAST : BIT_CYC_SLOW;

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            cs_prev_reg <= 1'b1;
            selected_reg <= 1'b0;
            access_reg <= '0;
        end else begin
            cs_prev_reg <= pins_reg.select_n;
            if (cs_fall) begin
                access_reg <= access_now;
                selected_reg <= 1'b1;
            end else if (cs_rise) begin
                selected_reg <= 1'b0;
            end
        end
    end

    // every side effect happens at select rise, when write data is valid
    assign rx_read = cs_rise && selected_reg && is_access(access_reg, SEL_RX_DATA, 1'b1);
    assign tx_write = cs_rise && selected_reg && is_access(access_reg, SEL_TX_DATA, 1'b0);
    assign rx_stat_write = cs_rise && selected_reg && is_access(access_reg, SEL_RX_STAT, 1'b0);
    assign tx_stat_write = cs_rise && selected_reg && is_access(access_reg, SEL_TX_STAT, 1'b0);

    // read data, invalid and transmit reads give a fixed value
    always_comb begin
        read_value = UNDEFINED_READ;
        if (access_now.rd) begin
            case (access_now.reg_sel)
                SEL_RX_DATA: read_value = receive_byte;
                SEL_RX_STAT: read_value = {6'h00, rx_ie_reg, data_present};
                SEL_TX_STAT: read_value = {6'h00, tx_ie_reg, out_ready_reg};
                default: read_value = UNDEFINED_READ;
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            HOST_BYTE_BUS_OUT <= 8'h00;
            HOST_BYTE_BUS_OE <= 1'b0;
        end else if (cs_fall) begin
            HOST_BYTE_BUS_OUT <= read_value;
            HOST_BYTE_BUS_OE <= access_now.rd;
        end else if (cs_rise) begin
            HOST_BYTE_BUS_OE <= 1'b0;
        end
    end

    // interrupt enables; other written bits are dropped so reserved bits read zero
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            rx_ie_reg <= IE_RESET;
            tx_ie_reg <= IE_RESET;
        end else begin
            if (rx_stat_write) begin
                rx_ie_reg <= pins_reg.data[IE_BIT];
            end
            if (tx_stat_write) begin
                tx_ie_reg <= pins_reg.data[IE_BIT];
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            RECEIVE_IRQ <= 1'b0;
            TRANSMIT_IRQ <= 1'b0;
        end else begin
            RECEIVE_IRQ <= rx_ie_reg && data_present;
            TRANSMIT_IRQ <= tx_ie_reg && out_ready_reg;
        end
    end

    // transmit side flags
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            tx_byte_reg <= 8'h00;
            tx_pending_reg <= 1'b0;
        end else begin
            if (tx_write) begin
                tx_byte_reg <= pins_reg.data;
            end
            tx_pending_reg <= tx_write || (tx_pending_reg && !start_data);
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            ack_pending_reg <= 1'b0;
        end else begin
            ack_pending_reg <= rx_read || (ack_pending_reg && !start_ack);
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            out_ready_reg <= OUT_READY_RESET;
            data_done_reg <= 1'b0;
            ack_seen_reg <= 1'b0;
        end else if (tx_write) begin
            out_ready_reg <= 1'b0;
            data_done_reg <= 1'b0;
            ack_seen_reg <= 1'b0;
        end else if (data_done_reg && ack_seen_reg) begin
            out_ready_reg <= 1'b1;
            data_done_reg <= 1'b0;
            ack_seen_reg <= ack_pulse_reg;
        end else begin
            data_done_reg <= data_done_reg || data_end;
            ack_seen_reg <= ack_seen_reg || (ack_pulse_reg && !out_ready_reg);
        end
    end

    // bit divider restarts from idle so a packet starts one full bit after its request
    assign tx_tick = tx_div_reg == bit_cyc - 4'h1;
    assign start_ack = tx_tick && (tx_state_reg == TX_IDLE) && ack_pending_reg;
    assign start_data = tx_tick && (tx_state_reg == TX_IDLE) && !ack_pending_reg
                        && tx_pending_reg;
    assign data_end = tx_tick && (tx_state_reg == TX_SEND) && (tx_cnt_reg == 4'h0)
                      && tx_sending_data_reg;

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            tx_div_reg <= 4'h0;
        end else if (tx_tick || (tx_state_reg == TX_IDLE && !ack_pending_reg
                                 && !tx_pending_reg)) begin
            tx_div_reg <= 4'h0;
        end else begin
            tx_div_reg <= tx_div_reg + 4'h1;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            tx_state_reg <= TX_IDLE;
            tx_cnt_reg <= 4'h0;
            tx_shift_reg <= 10'h000;
            tx_sending_data_reg <= 1'b0;
            SERIAL_OUT <= 1'b0;
        end else if (tx_tick) begin
            case (tx_state_reg)
                TX_IDLE: begin
                    if (start_ack) begin
                        SERIAL_OUT <= 1'b1;
                        tx_shift_reg <= 10'h000;
                        tx_cnt_reg <= ACK_FRAME_BITS - 4'h1;
                        tx_sending_data_reg <= 1'b0;
                        tx_state_reg <= TX_SEND;
                    end else if (start_data) begin
                        SERIAL_OUT <= 1'b1;
                        tx_shift_reg <= {1'b0, tx_byte_reg, 1'b1};
                        tx_cnt_reg <= DATA_FRAME_BITS - 4'h1;
                        tx_sending_data_reg <= 1'b1;
                        tx_state_reg <= TX_SEND;
                    end
                end
                TX_SEND: begin
                    if (tx_cnt_reg == 4'h0) begin
                        SERIAL_OUT <= 1'b0;
                        tx_state_reg <= TX_IDLE;
                    end else begin
                        SERIAL_OUT <= tx_shift_reg[0];
                        tx_shift_reg <= {1'b0, tx_shift_reg[9:1]};
                        tx_cnt_reg <= tx_cnt_reg - 4'h1;
                    end
                end
                default: tx_state_reg <= TX_IDLE;
            endcase
        end
    end

    // receiver samples mid-bit; acknowledges only flag the transmit side
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            rx_state_reg <= RX_IDLE;
            rx_cnt_reg <= 4'h0;
            rx_idx_reg <= 3'h0;
            rx_shift_reg <= 8'h00;
            rx_push_reg <= 1'b0;
            ack_pulse_reg <= 1'b0;
            serial_prev_reg <= 1'b0;
        end else begin
            serial_prev_reg <= pins_reg.serial;
            ack_pulse_reg <= 1'b0;
            if (rx_push_reg && fifo_in_ready) begin
                rx_push_reg <= 1'b0;
            end
            case (rx_state_reg)
                RX_IDLE: begin
                    if (pins_reg.serial && !serial_prev_reg) begin
                        rx_cnt_reg <= bit_cyc + {1'b0, bit_cyc[3:1]} - 4'h1;
                        rx_state_reg <= RX_TYPE;
                    end
                end
                RX_TYPE: begin
                    if (rx_cnt_reg != 4'h0) begin
                        rx_cnt_reg <= rx_cnt_reg - 4'h1;
                    end else if (pins_reg.serial) begin
                        rx_idx_reg <= 3'h0;
                        rx_cnt_reg <= bit_cyc - 4'h1;
                        rx_state_reg <= RX_DATA;
                    end else begin
                        ack_pulse_reg <= 1'b1;
                        rx_state_reg <= RX_IDLE;
                    end
                end
                RX_DATA: begin
                    if (rx_cnt_reg != 4'h0) begin
                        rx_cnt_reg <= rx_cnt_reg - 4'h1;
                    end else begin
                        rx_shift_reg <= {pins_reg.serial, rx_shift_reg[7:1]};
                        rx_cnt_reg <= bit_cyc - 4'h1;
                        rx_idx_reg <= rx_idx_reg + 3'h1;
                        if (rx_idx_reg == 3'h7) begin
                            rx_state_reg <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    // a byte still waiting on a full buffer stalls the next one here until it is taken
                    if (rx_cnt_reg != 4'h0) begin
                        rx_cnt_reg <= rx_cnt_reg - 4'h1;
                    end else if (!rx_push_reg) begin
                        rx_push_reg <= 1'b1;
                        rx_state_reg <= RX_IDLE;
                    end
                end
                default: rx_state_reg <= RX_IDLE;
            endcase
        end
    end

    // received bytes; head of buffer is the receive register, valid is data-present
    slhp_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .clock(CLOCK),
        .rst_n(RST_N),
        .in_valid(rx_push_reg),
        .in_data(rx_shift_reg),
        .in_ready(fifo_in_ready),
        .out_valid(data_present),
        .out_data(receive_byte),
        .out_ready(rx_read)
    );

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    bus_drive_a: assert property (HOST_BYTE_BUS_OE |-> selected_reg && access_reg.rd)
        else $error("bus driven while not selected for read");
    rx_irq_a: assert property (RECEIVE_IRQ == $past(rx_ie_reg && data_present))
        else $error("receive irq mismatch");
    tx_irq_a: assert property (TRANSMIT_IRQ == $past(tx_ie_reg && out_ready_reg))
        else $error("transmit irq mismatch");
    rx_clear_a: assert property (rx_read |-> ##[1:2] !RECEIVE_IRQ)
        else $error("receive irq not cleared by read");
    data_set_a: assert property (rx_push_reg && fifo_in_ready |=> data_present)
        else $error("data present not set");
    ready_clear_a: assert property (tx_write |=> !out_ready_reg ##1 !TRANSMIT_IRQ)
        else $error("output ready not cleared");
    ready_cause_a: assert property ($rose(out_ready_reg) |-> $past(data_done_reg)
                                    && $past(ack_seen_reg))
        else $error("output ready set early");
    ack_start_a: assert property (rx_read |-> ##[1:80] start_ack)
        else $error("acknowledge not started");
    data_start_a: assert property (tx_write |-> ##[1:30] start_data)
        else $error("data packet not started");
    idle_low_a: assert property (tx_state_reg == TX_IDLE && !$past(tx_state_reg == TX_SEND)
                                 |-> !SERIAL_OUT)
        else $error("link not idle low");

    rx_read_c: cover property (rx_read && RECEIVE_IRQ);
    tx_done_c: cover property ($rose(out_ready_reg) && tx_ie_reg);
    ack_wait_c: cover property (ack_pending_reg && tx_state_reg == TX_SEND
                                && tx_sending_data_reg);
endmodule

// *** test/slhp_peer.sv ***
// link peer model: sends data packets and acknowledges the ones it receives
`timescale 1ns/10ps
module slhp_peer import slhp_pkg::*; (
    // clock and link
    input wire logic clock,
    input wire logic din,
    input wire logic rate,
    output logic dout
);
    logic [7:0] last_rx = 8'h00;
    int acks = 0;
    int ack_delay = 0;
    int bc;
    assign bc = rate ? int'(BIT_CYC_FAST) : int'(BIT_CYC_SLOW);
    initial dout = 1'b0; // idle low
    task automatic put(input logic [10:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            dout <= v[i]; // lsb first
            repeat (bc) @(posedge clock);
        end
        dout <= 1'b0;
    endtask
    task automatic send(input logic [7:0] b);
        put({1'b0, b, 2'b11}, 11); // start, one, data, stop
    endtask
    // acknowledge every data packet, after an optional stall
    initial begin
        logic [8:0] sh;
        forever begin
            @(posedge clock);
            if (din === 1'b1) begin
                repeat (bc + bc / 2) @(posedge clock);
                if (din === 1'b0) begin
                    acks++; // acknowledge is 1,0
                end else begin
                    for (int i = 0; i < 9; i++) begin
                        repeat (bc) @(posedge clock);
                        sh[i] = din;
                    end
                    last_rx = sh[7:0];
                    repeat (bc + ack_delay) @(posedge clock);
                    put(11'h001, 2);
                end
            end
        end
    end
endmodule

// *** test/slhp_top_test.sv ***
// self-checking bench for the serial link host port
`timescale 1ns/10ps
module slhp_top_test import slhp_pkg::*; ();
    logic clk = 1'b0, rst_n = 1'b0, cs_n = 1'b1, rw = 1'b1, rate = 1'b0;
    logic [1:0] rs = 2'h0;
    logic [7:0] wd = 8'h00, dout, q;
    logic oe, rirq, tirq, so, si;
    int n_fail = 0, compares = 0, cyc = 0, n;
    typedef struct packed {
        logic [1:0] s;
        logic r;
        logic [7:0] d, q;
        logic ri, ti;
    } slhp_row_type;
    slhp_row_type rows [11] = '{
        '{2'h2, 1'b1, 8'h00, 8'h00, 1'b0, 1'b0}, '{2'h3, 1'b1, 8'h00, 8'h01, 1'b0, 1'b0},
        '{2'h2, 1'b0, 8'h02, 8'h00, 1'b0, 1'b0}, '{2'h2, 1'b1, 8'h00, 8'h02, 1'b0, 1'b0},
        '{2'h3, 1'b0, 8'h02, 8'h00, 1'b0, 1'b1}, '{2'h3, 1'b1, 8'h00, 8'h03, 1'b0, 1'b1},
        '{2'h1, 1'b1, 8'h00, 8'h00, 1'b0, 1'b1}, '{2'h0, 1'b0, 8'h55, 8'h00, 1'b0, 1'b1},
        '{2'h2, 1'b1, 8'h00, 8'h02, 1'b0, 1'b1}, '{2'h3, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0},
        '{2'h3, 1'b1, 8'h00, 8'h01, 1'b0, 1'b0}};
    slhp_top DUT (.CLOCK(clk), .RST_N(rst_n), .HOST_SELECT_LOW(cs_n),
        .REGISTER_SELECT_LINES(rs), .READ_WRITE_LINE(rw), .HOST_BYTE_BUS_IN(wd),
        .HOST_BYTE_BUS_OUT(dout), .HOST_BYTE_BUS_OE(oe), .RECEIVE_IRQ(rirq),
        .TRANSMIT_IRQ(tirq), .SERIAL_IN(si), .SERIAL_OUT(so), .SERIAL_RATE_SELECT(rate));
    slhp_peer peer (.clock(clk), .din(so), .rate(rate), .dout(si));
    initial forever #10 clk = ~clk;
    task automatic end_sim();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // hang guard, well above the longest sequence
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            end_sim();
        end
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one host cycle; select held low long enough for the pin synchronisers
    task automatic acc(input logic [1:0] s, input logic r, input logic [7:0] d);
        rs <= s; // set up before select falls
        rw <= r;
        wd <= d;
        @(posedge clk) cs_n <= 1'b0;
        repeat (7) @(posedge clk);
        q = dout;
        chk("bus enable", 8'(r), 8'(oe));
        rs <= ~s; // flipped after the fall, must be ignored
        rw <= ~r;
        repeat (2) @(posedge clk);
        cs_n <= 1'b1;
        repeat (8) @(posedge clk);
        chk("bus release", 8'h00, 8'(oe));
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk("reset pins", 8'h00, 8'({so, rirq, tirq, oe}));
        foreach (rows[i]) begin
            acc(rows[i].s, rows[i].r, rows[i].d);
            if (rows[i].r) chk("table read", rows[i].q, q);
            chk("rx irq", 8'(rows[i].ri), 8'(rirq));
            chk("tx irq", 8'(rows[i].ti), 8'(tirq));
        end
        fork
            peer.send(8'hA5);
            for (n = 0; n < 70 && rirq !== 1'b1; n++) @(posedge clk);
        join
        chk("rx irq rise", 8'h01, 8'(rirq));
        acc(SEL_RX_STAT, 1'b0, 8'h00);
        chk("rx irq masked", 8'h00, 8'(rirq));
        acc(SEL_RX_STAT, 1'b0, 8'h02);
        chk("rx irq again", 8'h01, 8'(rirq));
        acc(SEL_RX_DATA, 1'b1, 8'h00);
        chk("rx data", 8'hA5, q);
        chk("rx irq read", 8'h00, 8'(rirq));
        for (n = 0; n < 60 && peer.acks != 1; n++) @(posedge clk);
        chk("ack sent", 8'h01, 8'(peer.acks));
        acc(SEL_RX_STAT, 1'b1, 8'h00);
        chk("present cleared", 8'h02, q);
        acc(SEL_TX_STAT, 1'b0, 8'h02);
        for (int r = 0; r < 2; r++) begin
            rate <= 1'(r); // both link rates
            peer.ack_delay = 20 * r;
            acc(SEL_TX_DATA, 1'b0, 8'h3C ^ 8'(r * 255));
            chk("tx irq write", 8'h00, 8'(tirq));
            acc(SEL_TX_STAT, 1'b1, 8'h00);
            chk("ready low", 8'h02, q);
            for (n = 0; n < 300 && tirq !== 1'b1; n++) @(posedge clk);
            chk("ready irq", 8'h01, 8'(tirq));
            chk("tx byte", 8'h3C ^ 8'(r * 255), peer.last_rx);
        end
        rate <= 1'b0;
        repeat (8) @(posedge clk);
        // one byte at a time: each byte is read back before the next is sent
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            peer.send(8'(i * 7));
            repeat (5) @(posedge clk);
            acc(SEL_RX_DATA, 1'b1, 8'h00);
            chk("buffered byte", 8'(i * 7), q);
        end
        acc(SEL_RX_STAT, 1'b1, 8'h00);
        chk("drained", 8'h02, q);
        chk("ack count", 8'h21, 8'(peer.acks));
        end_sim();
    end
endmodule
